// ===== core/tdw_regs.vh
// register layout, field positions, reset values and state codes of the twelve bit wave counter
// assumes inclusion by core/tdw_core.v and by the monitor and the bench
// Function
// - enable changes only while enable ready, or clears at cycle end after disable command
// - other control A bits need enable low
// - fault control changes only after unlock
// - command strobes cross while enabled, idle
// - command strobe bits clear once sent
// - buffered writes accepted while disabled, or while enabled, idle
// - buffers copied on sync command or enable
// - auto update syncs at cycle end
// - sync now strobe syncs once immediately
// - end of cycle strobe syncs next cycle end
// - sync strobes ignored while sync busy
// - static registers frozen while counter enabled
// - status and capture readable without sync constraint
// - mode field picks one of four modes
// - cycle walks dead A, on A, dead B, on B; dual slope skips on A
// - ramp modes reset counter one, two, four times
// - dual slope counts down and up
// - one ramp period is clear B plus one
// - async input event overrides outputs immediately
// - blanking masks input for the delay count after entering chosen cycle part
// - counter clock divided by both prescalers
`ifndef TDW_REGS_VH
`define TDW_REGS_VH
// ===========================================================
// widths and field positions
`define TDW_CNT_W        12
`define TDW_CTLA_ENABLE  0
`define TDW_CTLA_CNTP_LO 3
`define TDW_CTLA_CNTP_HI 4
`define TDW_CTLA_SYNP_LO 1
`define TDW_CTLA_SYNP_HI 2
`define TDW_CMD_SYNC_END_OF_CYCLE_STROBE  0
`define TDW_CMD_SYNC     1
`define TDW_CMD_DISEOC   2
// ===========================================================
// waveform modes
`define TDW_MODE_ONE     2'h0
`define TDW_MODE_TWO     2'h1
`define TDW_MODE_FOUR    2'h2
`define TDW_MODE_DUAL    2'h3
// ===========================================================
// cycle states
`define TDW_ST_DTA       2'h0
`define TDW_ST_OTA       2'h1
`define TDW_ST_DTB       2'h2
`define TDW_ST_OTB       2'h3
// ===========================================================
// reset values and unlock window length
`define TDW_RST_CNT      12'h000
`define TDW_RST_CMP      12'h000
`define TDW_RST_COMPARE_B_CLEAR  12'hFFF
`define TDW_RST_BYTE     8'h00
`define TDW_RST_CMD      3'h0
`define TDW_UNLOCK_WIN   3'h4
`endif

// ===== core/tdw_core.v
// control core of the twelve bit wave counter: register synchronisation, buffers and cycle structure
// assumes a single sys_clk; the slow counter rate comes from an enable pulse, writes arrive as one-cycle strobes
`timescale 1ns/1ps
`include "tdw_regs.vh"
module tdw_core #(
    parameter DELAY_W = 8                       // blanking delay counter width
) (
    input  wire                 sys_clk,        // system clock, 40 MHz
    input  wire                 rst,            // async reset, high
    input  wire                 ctlAWrite,      // write strobe control A
    input  wire [4:0]           ctlAData,       // control A write data
    input  wire                 staticWrite,    // write strobe static block
    input  wire [1:0]           waveModeIn,     // waveform mode field data
    input  wire                 autoUpdateIn,   // auto update bit data
    input  wire                 unlockPulse,    // configuration change unlock
    input  wire                 faultWrite,     // fault control write strobe
    input  wire [7:0]           faultData,      // fault control data
    input  wire                 cmdWrite,       // command strobe write
    input  wire [2:0]           cmdData,        // command bits
    input  wire                 cmpWrite,       // compare write strobe
    input  wire [1:0]           cmpSel,         // 0 aset 1 aclr 2 bset 3 bclr
    input  wire [11:0]          cmpData,        // compare write value
    input  wire                 cmpBClrHighWrite, // high byte of clear B written
    input  wire                 dlyWrite,       // delay value write strobe
    input  wire [DELAY_W-1:0]   dlyData,        // delay value data
    input  wire [1:0]           blankPart,      // state that triggers blanking
    input  wire                 blankEnable,    // input blanking enable
    input  wire                 faultEvent,     // event input, from pin
    input  wire                 faultAsyncEn,   // direct override enable
    output reg                  enableReadyFlag, // enable ready status
    output reg                  commandReadyFlag, // command ready status
    output reg                  bufferReadyFlag, // buffer ready status
    output reg                  enableBit,      // control A enable read
    output reg  [3:0]           ctlAOut,        // control A other bits read
    output reg  [1:0]           waveModeOut,    // waveform mode read
    output reg  [7:0]           faultCtlOut,    // fault control read
    output reg  [11:0]          counterOut,     // counter value
    output reg  [1:0]           cycleState,     // current cycle state
    output reg                  captureEvent,   // unblanked event seen
    output wire                 waveformOutA,   // waveform output A
    output wire                 waveformOutB    // waveform output B
);
// ===========================================================
// input synchroniser
reg evMeta_r;
reg evSync_r;
always @(posedge sys_clk or posedge rst)
begin
    if (rst)
    begin
        evMeta_r <= 1'b0;
        evSync_r <= 1'b0;
    end
    else
    begin
        evMeta_r <= faultEvent;
        evSync_r <= evMeta_r;
    end
end
// ===========================================================
// control and static registers
reg [11:0] bufCmp_r [0:3];
reg [11:0] actCmp_r [0:3];
reg        autoUpd_r;
reg [2:0]  cmdPend_r;
reg        syncBusy_r;
reg        eocArm_r;
reg        enPend_r;
reg        disEoc_r;
reg [2:0]  unlockCnt_r;
reg [DELAY_W-1:0] dlyBuf_r;
reg [DELAY_W-1:0] dlyAct_r;
wire       cycleEnd;
always @(posedge sys_clk or posedge rst)
begin
    if (rst)
    begin
        enableBit   <= 1'b0;
        ctlAOut     <= 4'h0;
        waveModeOut <= `TDW_MODE_ONE;
        autoUpd_r   <= 1'b0;
        faultCtlOut <= `TDW_RST_BYTE;
        unlockCnt_r <= 3'h0;
        enPend_r    <= 1'b0;
    end
    else
    begin
        enPend_r <= 1'b0;
        if (unlockPulse)
            unlockCnt_r <= `TDW_UNLOCK_WIN;
        else if (unlockCnt_r != 3'h0)
            unlockCnt_r <= unlockCnt_r - 3'h1;
        if (ctlAWrite && enableReadyFlag)
        begin
            if (!enableBit && !ctlAData[`TDW_CTLA_ENABLE])
                ctlAOut <= ctlAData[4:1];
            enableBit <= ctlAData[`TDW_CTLA_ENABLE];
            enPend_r  <= ctlAData[`TDW_CTLA_ENABLE] & ~enableBit;
        end
        else if (disEoc_r && cycleEnd)
            enableBit <= 1'b0;
        if (staticWrite && !enableBit)
        begin
            waveModeOut <= waveModeIn;
            autoUpd_r   <= autoUpdateIn;
        end
        if (faultWrite && !enableBit && unlockCnt_r != 3'h0)
            faultCtlOut <= faultData;
    end
end
// ===========================================================
// counter rate divider, both prescalers multiplied
reg [2:0] synDiv_r;
reg [3:0] cntDiv_r;
wire [2:0] synTop = (3'h1 << ctlAOut[1:0]) - 3'h1;
wire [3:0] cntTop = (ctlAOut[3:2] == 2'h0) ? 4'h0 : (ctlAOut[3:2] == 2'h1) ? 4'h3 : 4'h7;
wire synTick = (synDiv_r == synTop);
wire cntTick = synTick && (cntDiv_r == cntTop);
always @(posedge sys_clk or posedge rst)
begin
    if (rst)
    begin
        synDiv_r <= 3'h0;
        cntDiv_r <= 4'h0;
    end
    else if (!enableBit)
    begin
        synDiv_r <= 3'h0;
        cntDiv_r <= 4'h0;
    end
    else
    begin
        synDiv_r <= synTick ? 3'h0 : synDiv_r + 3'h1;
        if (synTick)
            cntDiv_r <= (cntDiv_r == cntTop) ? 4'h0 : cntDiv_r + 4'h1;
    end
end
// ===========================================================
// command strobes and buffer synchronisation
wire idle = enableBit && !syncBusy_r;
wire syncNowDone = syncBusy_r && !eocArm_r && synTick;
wire syncEocDone = syncBusy_r && eocArm_r && cycleEnd;
wire syncDone = syncNowDone || syncEocDone || enPend_r;
integer i;
always @(posedge sys_clk or posedge rst)
begin
    if (rst)
    begin
        cmdPend_r  <= `TDW_RST_CMD;
        syncBusy_r <= 1'b0;
        eocArm_r   <= 1'b0;
        disEoc_r   <= 1'b0;
        dlyBuf_r   <= {DELAY_W{1'b0}};
        dlyAct_r   <= {DELAY_W{1'b0}};
        for (i = 0; i < 4; i = i + 1)
        begin
            bufCmp_r[i] <= `TDW_RST_CMP;
            actCmp_r[i] <= `TDW_RST_CMP;
        end
    end
    else
    begin
        if (cmdWrite && idle)
            cmdPend_r <= cmdData;
        else if (cmdPend_r != `TDW_RST_CMD && synTick)
            cmdPend_r <= `TDW_RST_CMD;
        if (cmdPend_r[`TDW_CMD_DISEOC] && synTick)
            disEoc_r <= 1'b1;
        else if (!enableBit)
            disEoc_r <= 1'b0;
        if (cmpWrite && (idle || !enableBit))
            bufCmp_r[cmpSel] <= cmpData;
        if (dlyWrite && (idle || !enableBit))
            dlyBuf_r <= dlyData;
        if (syncDone)
        begin
            syncBusy_r <= 1'b0;
            for (i = 0; i < 4; i = i + 1)
                actCmp_r[i] <= bufCmp_r[i];
            dlyAct_r <= dlyBuf_r;
        end
        else if (!syncBusy_r && enableBit)
        begin
            if (cmpBClrHighWrite && autoUpd_r)
            begin
                syncBusy_r <= 1'b1;
                eocArm_r   <= 1'b1;
            end
            else if (synTick && cmdPend_r[`TDW_CMD_SYNC])
            begin
                syncBusy_r <= 1'b1;
                eocArm_r   <= 1'b0;
            end
            else if (synTick && cmdPend_r[`TDW_CMD_SYNC_END_OF_CYCLE_STROBE])
            begin
                syncBusy_r <= 1'b1;
                eocArm_r   <= 1'b1;
            end
        end
        if (!enableBit)
            syncBusy_r <= 1'b0;
    end
end
// ===========================================================
// status flags, visible without synchronisation constraint
always @(posedge sys_clk or posedge rst)
begin
    if (rst)
    begin
        enableReadyFlag  <= 1'b1;
        commandReadyFlag <= 1'b1;
        bufferReadyFlag  <= 1'b1;
    end
    else
    begin
        enableReadyFlag  <= !enPend_r && !(ctlAWrite && enableReadyFlag);
        commandReadyFlag <= (cmdPend_r == `TDW_RST_CMD) && !cmdWrite;
        bufferReadyFlag  <= !syncBusy_r;
    end
end
// ===========================================================
// counter and cycle states
reg [11:0] cnt_r;
reg [1:0]  st_r;
reg        down_r;
reg [1:0]  outs_r;
wire [11:0] stEnd = actCmp_r[st_r];
wire atEnd = (cnt_r == stEnd);
assign cycleEnd = cntTick && (((waveModeOut == `TDW_MODE_DUAL) && !down_r && cnt_r == actCmp_r[3])
                  || ((waveModeOut != `TDW_MODE_DUAL) && atEnd && st_r == `TDW_ST_OTB)
                  || ((waveModeOut == `TDW_MODE_ONE) && cnt_r == actCmp_r[3]));
always @(posedge sys_clk or posedge rst)
begin
    if (rst)
    begin
        cnt_r  <= `TDW_RST_CNT;
        st_r   <= `TDW_ST_DTA;
        down_r <= 1'b1;
        outs_r <= 2'h0;
    end
    else if (!enableBit)
    begin
        cnt_r  <= (waveModeOut == `TDW_MODE_DUAL) ? actCmp_r[3] : `TDW_RST_CNT;
        st_r   <= `TDW_ST_DTA;
        down_r <= 1'b1;
        outs_r <= 2'h0;
    end
    else if (cntTick)
    begin
        case (waveModeOut)
        `TDW_MODE_ONE:
        begin
            cnt_r <= (cnt_r == actCmp_r[3]) ? `TDW_RST_CNT : cnt_r + 12'h001;
            if (cnt_r == actCmp_r[0]) outs_r[0] <= 1'b1;
            if (cnt_r == actCmp_r[1]) outs_r[0] <= 1'b0;
            if (cnt_r == actCmp_r[2]) outs_r[1] <= 1'b1;
            if (cnt_r == actCmp_r[3]) outs_r <= 2'h0;
            if (atEnd || cnt_r == actCmp_r[3])
                st_r <= (cnt_r == actCmp_r[3]) ? `TDW_ST_DTA : st_r + 2'h1;
        end
        `TDW_MODE_TWO:
        begin
            if (cnt_r == actCmp_r[{st_r[1], 1'b1}])
            begin
                cnt_r <= `TDW_RST_CNT;
                st_r  <= st_r[1] ? `TDW_ST_DTA : `TDW_ST_DTB;
                outs_r[st_r[1]] <= 1'b0;
            end
            else
            begin
                cnt_r <= cnt_r + 12'h001;
                if (cnt_r == actCmp_r[{st_r[1], 1'b0}])
                begin
                    outs_r[st_r[1]] <= 1'b1;
                    st_r <= {st_r[1], 1'b1};
                end
            end
        end
        `TDW_MODE_FOUR:
        begin
            cnt_r <= atEnd ? `TDW_RST_CNT : cnt_r + 12'h001;
            if (atEnd)
            begin
                st_r   <= st_r + 2'h1;
                outs_r <= (st_r == `TDW_ST_DTA) ? 2'h1 : (st_r == `TDW_ST_DTB) ? 2'h2 : 2'h0;
            end
        end
        default:
        begin
            if (down_r)
            begin
                if (cnt_r == actCmp_r[0]) outs_r[0] <= 1'b1;
                if (cnt_r == actCmp_r[2]) outs_r[1] <= 1'b0;
                down_r <= (cnt_r != `TDW_RST_CNT);
                cnt_r  <= (cnt_r == `TDW_RST_CNT) ? cnt_r + 12'h001 : cnt_r - 12'h001;
                st_r   <= (cnt_r == `TDW_RST_CNT) ? `TDW_ST_DTB : `TDW_ST_DTA;
            end
            else
            begin
                if (cnt_r == actCmp_r[0]) outs_r[0] <= 1'b0;
                if (cnt_r == actCmp_r[2]) outs_r[1] <= 1'b1;
                down_r <= (cnt_r == actCmp_r[3]);
                cnt_r  <= (cnt_r == actCmp_r[3]) ? cnt_r - 12'h001 : cnt_r + 12'h001;
                st_r   <= (cnt_r == actCmp_r[3]) ? `TDW_ST_DTA : `TDW_ST_OTB;
            end
        end
        endcase
    end
end
// ===========================================================
// input blanking and output override
reg [DELAY_W-1:0] blankCnt_r;
reg [1:0]         lastSt_r;
reg               faultHold_r;
wire blanking = (blankCnt_r != {DELAY_W{1'b0}});
wire evLive = evSync_r && !blanking;
always @(posedge sys_clk or posedge rst)
begin
    if (rst)
    begin
        blankCnt_r   <= {DELAY_W{1'b0}};
        lastSt_r     <= `TDW_ST_DTA;
        faultHold_r  <= 1'b0;
        captureEvent <= 1'b0;
        counterOut   <= `TDW_RST_CNT;
        cycleState   <= `TDW_ST_DTA;
    end
    else
    begin
        lastSt_r   <= st_r;
        counterOut <= cnt_r;
        cycleState <= st_r;
        captureEvent <= evLive;
        if (blankEnable && st_r == blankPart && lastSt_r != st_r)
            blankCnt_r <= dlyAct_r;
        else if (blanking && synTick)
            blankCnt_r <= blankCnt_r - {{(DELAY_W-1){1'b0}}, 1'b1};
        if (!enableBit)
            faultHold_r <= 1'b0;
        else if (evLive)
            faultHold_r <= 1'b1;
    end
end
// direct override uses the raw pin path so the outputs drop without clock delay
assign waveformOutA = outs_r[0] && !faultHold_r && !(faultAsyncEn && faultEvent);
assign waveformOutB = outs_r[1] && !faultHold_r && !(faultAsyncEn && faultEvent);
endmodule // tdw_core

// ===== dv/tdw_core_monitor.sv
// concurrent checks on the ports of the twelve bit wave counter core
// assumes it is bound into tdw_core, one clock sys_clk, async reset rst
`timescale 1ns/1ps
`include "tdw_regs.vh"
module tdw_core_monitor (
    input wire        sys_clk,          // system clock
    input wire        rst,              // async reset, high
    input wire        ctlAWrite,        // control A write
    input wire [4:0]  ctlAData,         // control A data
    input wire        staticWrite,      // static write
    input wire        faultWrite,       // fault control write
    input wire        cmdWrite,         // command write
    input wire [2:0]  cmdData,          // command bits
    input wire        faultEvent,       // event input
    input wire        faultAsyncEn,     // direct override enable
    input wire        enableReadyFlag,  // enable ready
    input wire        commandReadyFlag, // command ready
    input wire        bufferReadyFlag,  // buffer ready
    input wire        enableBit,        // enable readback
    input wire [3:0]  ctlAOut,          // control A readback
    input wire [1:0]  waveModeOut,      // mode readback
    input wire [7:0]  faultCtlOut,      // fault readback
    input wire [11:0] counterOut,       // counter value
    input wire [1:0]  cycleState,       // cycle state
    input wire        waveformOutA,     // output A
    input wire        waveformOutB      // output B
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ===========================================================
    // enable and command handshake
    AST_EN_TAKEN: assert property (ctlAWrite && enableReadyFlag |=> enableBit == $past(ctlAData[0]))
        else $error("enable write not taken");
    AST_EN_REFUSED: assert property (ctlAWrite && !enableReadyFlag |=> $stable(enableBit))
        else $error("enable changed while not ready");
    AST_EN_READY: assert property ($fell(enableReadyFlag) |-> ##[1:20] enableReadyFlag)
        else $error("enable ready never returned");
    AST_CMD_BUSY: assert property (cmdWrite && cmdData != 3'h0 && enableBit && commandReadyFlag && bufferReadyFlag
        |=> !commandReadyFlag)
        else $error("command not taken");
    AST_CMD_CLEAR: assert property ($fell(commandReadyFlag) |-> ##[1:300] commandReadyFlag)
        else $error("command bits never cleared");
    // ===========================================================
    // protected and static settings
    AST_CTLA_PROT: assert property (ctlAWrite && enableBit |=> $stable(ctlAOut))
        else $error("control A bits changed while enabled");
    AST_FAULT_GUARD: assert property ($changed(faultCtlOut) |-> $past(faultWrite) && !$past(enableBit))
        else $error("fault control changed without disabled write");
    AST_STATIC_FROZEN: assert property (staticWrite && enableBit |=> $stable(waveModeOut))
        else $error("mode changed while enabled");
    // ===========================================================
    // cycle structure and override
    AST_STATE_ORDER: assert property (enableBit && $past(enableBit) && $past(enableBit, 2) && $changed(cycleState)
        |-> cycleState == $past(cycleState) + 2'h1)
        else $error("cycle state out of order");
    AST_RAMP_STEP: assert property (enableBit && $past(enableBit) && $past(enableBit, 2)
        && waveModeOut == `TDW_MODE_ONE && $changed(counterOut)
        |-> counterOut == $past(counterOut) + 12'h001 || counterOut == 12'h000)
        else $error("one ramp counter step wrong");
    AST_ASYNC_OVR: assert property (faultAsyncEn && faultEvent |-> !waveformOutA && !waveformOutB)
        else $error("outputs not overridden");
    cover property (ctlAWrite && enableReadyFlag && ctlAData[0]);
    cover property ($fell(commandReadyFlag));
    cover property (faultAsyncEn && faultEvent);
endmodule // tdw_core_monitor

bind tdw_core tdw_core_monitor i_tdw_core_monitor (.sys_clk(sys_clk), .rst(rst), .ctlAWrite(ctlAWrite),
    .ctlAData(ctlAData), .staticWrite(staticWrite), .faultWrite(faultWrite), .cmdWrite(cmdWrite),
    .cmdData(cmdData), .faultEvent(faultEvent), .faultAsyncEn(faultAsyncEn), .enableReadyFlag(enableReadyFlag),
    .commandReadyFlag(commandReadyFlag), .bufferReadyFlag(bufferReadyFlag), .enableBit(enableBit),
    .ctlAOut(ctlAOut), .waveModeOut(waveModeOut), .faultCtlOut(faultCtlOut), .counterOut(counterOut),
    .cycleState(cycleState), .waveformOutA(waveformOutA), .waveformOutB(waveformOutB));

// ===== dv/test_tdw_core.sv
// self-checking bench for tdw_core: register writes, sync commands, periods, override
// assumes the core alone, driven 1 ns after each rising edge
`timescale 1ns/1ps
`include "tdw_regs.vh"
module test_tdw_core;
    reg         sys_clk = 1'b0, rst = 1'b1;
    reg         ctlAWrite = 0, staticWrite = 0, autoUpdateIn = 0, unlockPulse = 0, faultWrite = 0;
    reg         cmdWrite = 0, cmpWrite = 0, cmpBClrHighWrite = 0, faultEvent = 0, faultAsyncEn = 0;
    reg  [4:0]  ctlAData = 0;
    reg         dlyWrite = 0, blankEnable = 0;
    reg  [1:0]  waveModeIn = 0, cmpSel = 0, blankPart = 0;
    reg  [7:0]  faultData = 0, dlyData = 0;
    reg  [2:0]  cmdData = 0;
    reg  [11:0] cmpData = 0;
    wire        enableReadyFlag, commandReadyFlag, bufferReadyFlag, enableBit, captureEvent;
    wire        waveformOutA, waveformOutB;
    wire [3:0]  ctlAOut;
    wire [1:0]  waveModeOut, cycleState;
    wire [7:0]  faultCtlOut;
    wire [11:0] counterOut;
    integer     badCount = 0, nCompared = 0, i, n;
    always #12.5 sys_clk = ~sys_clk;
    tdw_core i_tdw_core (.sys_clk(sys_clk), .rst(rst), .ctlAWrite(ctlAWrite), .ctlAData(ctlAData),
        .staticWrite(staticWrite), .waveModeIn(waveModeIn), .autoUpdateIn(autoUpdateIn), .unlockPulse(unlockPulse),
        .faultWrite(faultWrite), .faultData(faultData), .cmdWrite(cmdWrite), .cmdData(cmdData),
        .cmpWrite(cmpWrite), .cmpSel(cmpSel), .cmpData(cmpData), .cmpBClrHighWrite(cmpBClrHighWrite),
        .dlyWrite(dlyWrite), .dlyData(dlyData), .blankPart(blankPart), .blankEnable(blankEnable),
        .faultEvent(faultEvent),
        .faultAsyncEn(faultAsyncEn), .enableReadyFlag(enableReadyFlag), .commandReadyFlag(commandReadyFlag),
        .bufferReadyFlag(bufferReadyFlag), .enableBit(enableBit), .ctlAOut(ctlAOut), .waveModeOut(waveModeOut),
        .faultCtlOut(faultCtlOut), .counterOut(counterOut), .cycleState(cycleState), .captureEvent(captureEvent),
        .waveformOutA(waveformOutA), .waveformOutB(waveformOutB));
    // ===========================================================
    // access tasks
    task wrapUp;
    begin
        $display("compared %0d mismatches %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    task tick;
    begin
        @(posedge sys_clk);
        #1;
    end
    endtask
    task chk(input string nm, input [11:0] e, input [11:0] g);
    begin
        nCompared = nCompared + 1;
        if (g !== e)
        begin
            $display("unexpected %0s expected %h seen %h", nm, e, g);
            badCount = badCount + 1;
        end
    end
    endtask
    task waitHi(input integer k);
    begin
        i = 0;
        while (!(k == 0 ? enableReadyFlag === 1'b1 : k == 1 ? commandReadyFlag === 1'b1 : bufferReadyFlag === 1'b1)
            && i < 400)
        begin
            tick;
            i = i + 1;
        end
        if (i >= 400)
        begin
            $display("unexpected timeout on ready flag %0d", k);
            badCount = badCount + 1;
            wrapUp;
        end
    end
    endtask
    task wrA(input [4:0] d);
    begin
        ctlAData = d;
        ctlAWrite = 1;
        tick;
        ctlAWrite = 0;
        tick;
    end
    endtask
    task wrS(input [1:0] m, input au);
    begin
        waveModeIn = m;
        autoUpdateIn = au;
        staticWrite = 1;
        tick;
        staticWrite = 0;
        tick;
    end
    endtask
    task wrF(input unl, input [7:0] d);
    begin
        unlockPulse = unl;
        tick;
        unlockPulse = 0;
        faultData = d;
        faultWrite = 1;
        tick;
        faultWrite = 0;
        tick;
    end
    endtask
    task wrC(input [1:0] s, input [11:0] v);
    begin
        waitHi(2);
        cmpSel = s;
        cmpData = v;
        cmpWrite = 1;
        tick;
        cmpWrite = 0;
        tick;
    end
    endtask
    task cmd(input [2:0] d);
    begin
        waitHi(1);
        waitHi(2);
        cmdData = d;
        cmdWrite = 1;
        tick;
        cmdWrite = 0;
        repeat (4) tick;
        waitHi(1);
        waitHi(2);
    end
    endtask
    // counts cycles up to the next wrap of the counter to zero
    task wrapW;
        reg [11:0] p;
    begin
        n = 0;
        p = 12'h000;
        while (!(counterOut === 12'h000 && p !== 12'h000) && n < 2000)
        begin
            p = counterOut;
            tick;
            n = n + 1;
        end
        if (n >= 2000)
        begin
            $display("unexpected timeout on counter wrap");
            badCount = badCount + 1;
            wrapUp;
        end
    end
    endtask
    task period(input [11:0] e);
    begin
        wrapW;
        wrapW;
        wrapW;
        chk("cycle period", e, n[11:0]);
    end
    endtask
    // ===========================================================
    // main sequence
    initial
    begin
        #2000000;
        $display("unexpected overall timeout");
        badCount = badCount + 1;
        wrapUp;
    end
    initial
    begin
        repeat (10) tick;
        rst = 0;
        chk("enable ready", 1, enableReadyFlag);
        chk("command ready", 1, commandReadyFlag);
        chk("buffer ready", 1, bufferReadyFlag);
        chk("enable bit", 0, enableBit);
        wrA(5'h1E);
        chk("control A bits", 4'hF, ctlAOut);
        wrA(5'h00);
        chk("control A bits", 4'h0, ctlAOut);
        for (integer m = 3; m >= 0; m = m - 1)
        begin
            wrS(m[1:0], 1'b1);
            chk("wave mode", m[11:0], waveModeOut);
        end
        wrF(1'b0, 8'hA5);
        chk("fault control", 8'h00, faultCtlOut);
        wrF(1'b1, 8'hA5);
        chk("fault control", 8'hA5, faultCtlOut);
        wrC(2'h0, 12'h002);
        wrC(2'h1, 12'h005);
        wrC(2'h2, 12'h008);
        wrC(2'h3, 12'h00B);
        waitHi(0);
        ctlAData = 5'h01;
        ctlAWrite = 1;
        tick;
        chk("enable ready", 0, enableReadyFlag);
        ctlAData = 5'h00;
        tick;
        ctlAWrite = 0;
        chk("enable bit", 1, enableBit);
        period(12'd12);
        wrS(2'h3, 1'b1);
        chk("wave mode", 2'h0, waveModeOut);
        waitHi(0);
        wrA(5'h1F);
        chk("control A bits", 4'h0, ctlAOut);
        wrF(1'b1, 8'h3C);
        chk("fault control", 8'hA5, faultCtlOut);
        wrC(2'h3, 12'h00F);
        cmd(3'h1 << `TDW_CMD_SYNC);
        period(12'd16);
        wrC(2'h3, 12'h013);
        cmpBClrHighWrite = 1;
        tick;
        cmpBClrHighWrite = 0;
        period(12'd20);
        wrC(2'h3, 12'h009);
        cmd(3'h1 << `TDW_CMD_SYNC_END_OF_CYCLE_STROBE);
        period(12'd10);
        waitHi(0);
        wrA(5'h00);
        chk("enable bit", 0, enableBit);
        waitHi(0);
        wrA(5'h0A);
        chk("control A bits", 4'h5, ctlAOut);
        dlyData = 8'h10;
        blankPart = `TDW_ST_OTA;
        blankEnable = 1;
        dlyWrite = 1;
        tick;
        dlyWrite = 0;
        waitHi(0);
        wrA(5'h0B);
        period(12'd80);
        i = 0;
        while (cycleState !== `TDW_ST_OTA && i < 400)
        begin
            tick;
            i = i + 1;
        end
        tick;
        tick;
        chk("output A on time", 1, waveformOutA);
        faultAsyncEn = 1;
        faultEvent = 1;
        #1;
        chk("output A override", 0, waveformOutA);
        chk("output B override", 0, waveformOutB);
        repeat (3) tick;
        chk("blanked event", 0, captureEvent);
        faultAsyncEn = 0;
        repeat (40) tick;
        chk("unblanked event", 1, captureEvent);
        faultEvent = 0;
        tick;
        wrapUp;
    end
endmodule // test_tdw_core
